// File: logic/npc_core.sv
// Program-control and register core of a 4-bit microcontroller
// ============================================================
// Summary of operation
// - Carry set by add-with-carry; other adds keep it
// - Rotate right moves accumulator bit 0 to carry
// - Dedicated ops force carry one or zero
// - E copies to and from B high, A low
// - D and A form 7-bit in-page address
// - Eight stack entries for irq, call, table
// - Stack pointer wraps 7 to 0, overwrites entry
// - Pointer is 7 after reset and back-up return
// - Stack pointer copies into accumulator
// - Irq entry saves DP, carry, skip, A, B
// - Skip flag decides skips, saved over interrupts
// - PC increments, rolls 127 into next page
// - Program words are 10 bits, 128-word pages
// - Vectors sit at 0080h to 008Eh
// - Short call reaches 0100h to 017Fh anywhere
// - Table read returns word bits 7 to 0
// - DP is Z, X, Y; Y selects port bit
// - Memory words 4 bits, bit ops everywhere
// - Irq needs request, enable bit, global enable
// - Global enable set, cleared, auto-cleared on entry
// - Enable bit picks interrupt or skip test
// - Enable one: irq on, skip test ineffective
// - Request sets always, holds until taken or skipped
// - Enable takes effect after one more instruction
`timescale 1ns/10ps
module npc_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Program memory
	output logic [npc_pkg::PC_W-1:0] rom_addr_o,
	input wire logic [9:0] rom_data_i,
	// Interrupt sources and power control
	input wire logic [npc_pkg::NSRC-1:0] irq_event_i,
	input wire logic backup_return_i,
	// Port D
	input wire logic [7:0] port_d_i,
	output logic [7:0] port_d_o
);
	import npc_pkg::*;

	// ============================================================
	// State
	npc_state_t st_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [3:0] a_q;
	logic [3:0] b_q;
	logic [2:0] d_q;
	logic [7:0] e_q;
	logic [3:0] mem_q;
	logic [DP_W-1:0] dp_q;
	logic carry_q;
	logic skip_q;
	logic global_irq_enable_q;
	logic ei_wait_q;
	logic [2:0] sp_q;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] rom_q;
	logic [PC_W-1:0] stk_q [8];
	npc_save_t save_q;
	logic [NSRC-1:0] req_q;
	logic [NSRC-1:0] en_q;
	logic [7:0] pd_meta_q;
	logic [7:0] pd_q;
	logic [7:0] port_q;

	// ============================================================
	// Decode
	npc_cmd_t cmd;
	logic cmd_go;
	logic run;
	logic grant;
	logic irq_go;
	logic irq_take;
	logic [NSRC-1:0] pend;
	logic [2:0] irq_idx;
	logic [4:0] sum;
	logic [3:0] bmask;
	logic skip_d;
	logic push;
	logic pop;
	logic [2:0] sp_up;
	logic [PC_W-1:0] push_val;
	npc_core_t core_w;
	npc_data_t data_w;
	npc_irq_t irq_w;

	assign cmd = writedata_i[$bits(npc_cmd_t)-1:0];
	// A command runs only at the edge where the master sees waitrequest low
	assign cmd_go = write_i && !wait_q && address_i == OFS_CMD && byteenable_i[0];
	assign run = cmd_go && !skip_q;
	assign pend = req_q & en_q;
	assign irq_go = global_irq_enable_q && (|pend);
	assign irq_take = irq_go && st_q == ST_IDLE && !cmd_go;
	// Pending interrupts hold the bus off so entry never races a command
	assign grant = (read_i || write_i) && wait_q && st_q == ST_IDLE && !irq_go;
	assign sum = 5'(a_q) + 5'(cmd.arg[3:0]) + 5'(cmd.op == OP_ADD_CARRY && carry_q);
	assign bmask = 4'h1 << cmd.arg[5:4];
	assign sp_up = sp_q + 3'h1;
	assign push = irq_take || (run && (cmd.op == OP_CALL || cmd.op == OP_SHORT_CALL
		|| cmd.op == OP_IND_CALL || cmd.op == OP_TABLE_READ));
	assign pop = st_q == ST_LOAD || (run && (cmd.op == OP_RETURN || cmd.op == OP_IRQ_RETURN));
	assign push_val = irq_take ? pc_q : pc_q + 13'h1;
	assign core_w = '{rsv: '0, global_irq_enable: global_irq_enable_q, sp: sp_q, skip: skip_q, carry: carry_q, d: d_q, b: b_q, a: a_q};
	assign data_w = '{rsv: '0, mem: mem_q, dp: dp_q, e: e_q};
	assign irq_w = '{rsv: '0, en: en_q, req: req_q};

	// Lowest source number has the highest priority
	always_comb begin
		irq_idx = 3'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				irq_idx = 3'(i);
			end
		end
	end

	always_comb begin
		skip_d = 1'b0;
		if (run) begin
			case (cmd.op)
				OP_IRQ_RETURN: skip_d = save_q.skip;
				OP_IRQ_SKIP: skip_d = req_q[cmd.arg[2:0]] && !en_q[cmd.arg[2:0]];
				OP_BIT_TEST: skip_d = !cmd.arg[cmd.arg[5:4]];
				OP_PORT_TEST: skip_d = !dp_q[3] && !pd_q[dp_q[2:0]];
				default: skip_d = 1'b0;
			endcase
		end
	end

	// ============================================================
	// Bus slave
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !grant;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0;
		end else if (grant && read_i) begin
			case (address_i)
				OFS_CORE: rdata_q <= core_w;
				OFS_PC: rdata_q <= 32'(pc_q);
				OFS_DATA: rdata_q <= data_w;
				OFS_IRQ: rdata_q <= irq_w;
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	// ============================================================
	// Sequencer for the two-cycle table fetch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: st_q <= (run && cmd.op == OP_TABLE_READ) ? ST_FETCH : ST_IDLE;
				ST_FETCH: st_q <= ST_LOAD;
				ST_LOAD: st_q <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// Data registers and carry
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			a_q <= 4'h0;
			b_q <= 4'h0;
			d_q <= 3'h0;
			e_q <= 8'h0;
			mem_q <= 4'h0;
			dp_q <= '0;
			carry_q <= 1'b0;
		end else if (st_q == ST_LOAD) begin
			a_q <= rom_data_i[3:0];
			b_q <= rom_data_i[7:4];
		end else if (run) begin
			case (cmd.op)
				OP_LOAD_A: a_q <= cmd.arg[3:0];
				OP_LOAD_B: b_q <= cmd.arg[3:0];
				OP_LOAD_D: d_q <= cmd.arg[2:0];
				OP_LOAD_DP: dp_q <= cmd.arg[9:0];
				OP_ADD_IMM, OP_MEM_ADD: a_q <= sum[3:0];
				OP_ADD_CARRY: begin
					a_q <= sum[3:0];
					carry_q <= sum[4];
				end
				OP_ROT_RIGHT: begin
					a_q <= {carry_q, a_q[3:1]};
					carry_q <= a_q[0];
				end
				OP_CARRY_ONE: carry_q <= 1'b1;
				OP_CARRY_ZERO: carry_q <= 1'b0;
				OP_E_FROM_AB: e_q <= {b_q, a_q};
				OP_AB_FROM_E: begin
					b_q <= e_q[7:4];
					a_q <= e_q[3:0];
				end
				OP_SP_TO_A: a_q <= {1'b0, sp_q};
				OP_IRQ_RETURN: begin
					a_q <= save_q.a;
					b_q <= save_q.b;
					carry_q <= save_q.carry;
					dp_q <= save_q.dp;
				end
				OP_BIT_SET: mem_q <= cmd.arg[3:0] | bmask;
				OP_BIT_CLR: mem_q <= cmd.arg[3:0] & ~bmask;
				default: ;
			endcase
		end
	end

	// ============================================================
	// Skip flag and global interrupt enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			skip_q <= 1'b0;
			global_irq_enable_q <= 1'b0;
			ei_wait_q <= 1'b0;
		end else if (irq_take) begin
			skip_q <= 1'b0;
			global_irq_enable_q <= 1'b0;
			ei_wait_q <= 1'b0;
		end else if (cmd_go) begin
			skip_q <= skip_d;
			if (run && cmd.op == OP_IRQ_OFF) begin
				global_irq_enable_q <= 1'b0;
				ei_wait_q <= 1'b0;
			end else if (run && cmd.op == OP_IRQ_ON) begin
				ei_wait_q <= 1'b1;
			end else if (ei_wait_q) begin
				global_irq_enable_q <= 1'b1;
				ei_wait_q <= 1'b0;
			end
		end
	end

	// Single-stage save; calls and table reads never touch it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			save_q <= '0;
		end else if (irq_take) begin
			save_q <= '{dp: dp_q, carry: carry_q, skip: skip_q, a: a_q, b: b_q};
		end
	end

	// ============================================================
	// Return stack and program counter
	always_ff @(posedge clk_i) begin
		if (push) begin
			stk_q[sp_up] <= push_val;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sp_q <= SP_RESET;
		end else if (backup_return_i) begin
			sp_q <= SP_RESET;
		end else if (push) begin
			sp_q <= sp_up;
		end else if (pop) begin
			sp_q <= sp_q - 3'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_q <= '0;
			rom_q <= '0;
		end else if (irq_take) begin
			pc_q <= VEC_BASE | 13'({irq_idx, 1'b0});
		end else if (pop) begin
			pc_q <= stk_q[sp_q];
		end else if (run) begin
			case (cmd.op)
				OP_BRANCH, OP_CALL: pc_q <= cmd.arg;
				OP_SHORT_CALL: pc_q <= SHORT_BASE | 13'(cmd.arg[6:0]);
				OP_IND_BRANCH, OP_IND_CALL: pc_q <= {cmd.arg[5:0], d_q, a_q};
				OP_TABLE_READ: begin
					rom_q <= {cmd.arg[5:0], d_q, a_q};
					pc_q <= pc_q + 13'h1;
				end
				default: pc_q <= pc_q + 13'h1;
			endcase
		end else if (cmd_go) begin
			pc_q <= pc_q + 13'h1;
		end
	end

	// ============================================================
	// Request flags and enable bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= '0;
		end else if (write_i && !wait_q && address_i == OFS_IRQ && byteenable_i[1]) begin
			en_q <= writedata_i[15:8];
		end
	end

	for (genvar i = 0; i < NSRC; i++) begin : g_req
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				req_q[i] <= 1'b0;
			end else if (irq_event_i[i]) begin
				req_q[i] <= 1'b1;
			end else if ((irq_take && irq_idx == 3'(i))
				|| (run && cmd.op == OP_IRQ_SKIP && cmd.arg[2:0] == 3'(i) && !en_q[i])) begin
				req_q[i] <= 1'b0;
			end
		end
	end

	// ============================================================
	// Port D latch and pin synchroniser
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_meta_q <= 8'h0;
			pd_q <= 8'h0;
		end else begin
			pd_meta_q <= port_d_i;
			pd_q <= pd_meta_q;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_q <= 8'h0;
		end else if (run && !dp_q[3] && cmd.op == OP_PORT_SET) begin
			port_q[dp_q[2:0]] <= 1'b1;
		end else if (run && !dp_q[3] && cmd.op == OP_PORT_CLR) begin
			port_q[dp_q[2:0]] <= 1'b0;
		end
	end

	assign readdata_o = rdata_q;
	assign waitrequest_o = wait_q;
	assign rom_addr_o = rom_q;
	assign port_d_o = port_q;

	// ============================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_adc_carry: assert property (run && cmd.op == OP_ADD_CARRY |=> carry_q == $past(sum[4]))
		else $error("carry not taken from add");
	chk_imm_keep: assert property (run && cmd.op == OP_ADD_IMM |=> $stable(carry_q))
		else $error("immediate add changed carry");
	chk_rot_carry: assert property (run && cmd.op == OP_ROT_RIGHT |=> carry_q == $past(a_q[0]))
		else $error("rotate did not move bit 0");
	chk_call_push: assert property (run && cmd.op == OP_CALL
		|=> sp_q == $past(sp_up) && stk_q[sp_q] == $past(pc_q) + 13'h1)
		else $error("call did not push return address");
	chk_sp_wrap: assert property (push && !backup_return_i && sp_q == 3'h7 |=> sp_q == 3'h0)
		else $error("stack pointer did not wrap");
	chk_irq_gate: assert property (irq_take |-> global_irq_enable_q && en_q[irq_idx] && req_q[irq_idx])
		else $error("interrupt taken without all conditions");
	chk_irq_entry: assert property (irq_take
		|=> !global_irq_enable_q && pc_q == (VEC_BASE | 13'({$past(irq_idx), 1'b0})))
		else $error("interrupt entry wrong");
	chk_irq_save: assert property (irq_take |=> save_q.a == $past(a_q) && save_q.skip == $past(skip_q))
		else $error("save register not loaded");
	chk_ei_delay: assert property (run && cmd.op == OP_IRQ_ON && !global_irq_enable_q |=> !global_irq_enable_q)
		else $error("enable took effect at once");
	chk_table_data: assert property (st_q == ST_FETCH
		##1 st_q == ST_LOAD |=> b_q == $past(rom_data_i[7:4]) && a_q == $past(rom_data_i[3:0]))
		else $error("table data not loaded");
	chk_rti_restore: assert property (run && cmd.op == OP_IRQ_RETURN
		|=> a_q == $past(save_q.a) && carry_q == $past(save_q.carry))
		else $error("return did not restore state");

	cov_irq_taken: cover property (irq_take ##[1:40] (run && cmd.op == OP_IRQ_RETURN));
	cov_table: cover property (run && cmd.op == OP_TABLE_READ ##3 st_q == ST_IDLE);
	cov_wrap: cover property (push && sp_q == 3'h7);
endmodule : npc_core

// File: logic/npc_pkg.sv
// Constants and types shared by the nibble CPU program-control core
package npc_pkg;
	// ============================================================
	// Sizes and fixed addresses
	localparam int PC_W = 13;
	localparam int DP_W = 10;
	localparam int NSRC = 8;
	localparam logic [2:0] SP_RESET = 3'h7;
	localparam logic [12:0] VEC_BASE = 13'h0080;
	localparam logic [12:0] SHORT_BASE = 13'h0100;
	// ============================================================
	// Register byte offsets
	localparam logic [4:0] OFS_CMD = 5'h00;
	localparam logic [4:0] OFS_CORE = 5'h04;
	localparam logic [4:0] OFS_PC = 5'h08;
	localparam logic [4:0] OFS_DATA = 5'h0c;
	localparam logic [4:0] OFS_IRQ = 5'h10;
	// ============================================================
	// Operation codes
	localparam logic [4:0] OP_NOP = 5'h00;
	localparam logic [4:0] OP_LOAD_A = 5'h01;
	localparam logic [4:0] OP_LOAD_B = 5'h02;
	localparam logic [4:0] OP_LOAD_D = 5'h03;
	localparam logic [4:0] OP_LOAD_DP = 5'h04;
	localparam logic [4:0] OP_ADD_IMM = 5'h05;
	localparam logic [4:0] OP_MEM_ADD = 5'h06;
	localparam logic [4:0] OP_ADD_CARRY = 5'h07;
	localparam logic [4:0] OP_ROT_RIGHT = 5'h08;
	localparam logic [4:0] OP_CARRY_ONE = 5'h09;
	localparam logic [4:0] OP_CARRY_ZERO = 5'h0a;
	localparam logic [4:0] OP_E_FROM_AB = 5'h0b;
	localparam logic [4:0] OP_AB_FROM_E = 5'h0c;
	localparam logic [4:0] OP_SP_TO_A = 5'h0d;
	localparam logic [4:0] OP_BRANCH = 5'h0e;
	localparam logic [4:0] OP_CALL = 5'h0f;
	localparam logic [4:0] OP_SHORT_CALL = 5'h10;
	localparam logic [4:0] OP_RETURN = 5'h11;
	localparam logic [4:0] OP_IRQ_RETURN = 5'h12;
	localparam logic [4:0] OP_IND_BRANCH = 5'h13;
	localparam logic [4:0] OP_IND_CALL = 5'h14;
	localparam logic [4:0] OP_TABLE_READ = 5'h15;
	localparam logic [4:0] OP_IRQ_ON = 5'h16;
	localparam logic [4:0] OP_IRQ_OFF = 5'h17;
	localparam logic [4:0] OP_IRQ_SKIP = 5'h18;
	localparam logic [4:0] OP_BIT_SET = 5'h19;
	localparam logic [4:0] OP_BIT_CLR = 5'h1a;
	localparam logic [4:0] OP_BIT_TEST = 5'h1b;
	localparam logic [4:0] OP_PORT_SET = 5'h1c;
	localparam logic [4:0] OP_PORT_CLR = 5'h1d;
	localparam logic [4:0] OP_PORT_TEST = 5'h1e;
	// ============================================================
	// Carriers and register layouts
	typedef struct packed {
		logic [12:0] arg;
		logic [4:0] op;
	} npc_cmd_t;
	typedef struct packed {
		logic [9:0] dp;
		logic carry;
		logic skip;
		logic [3:0] a;
		logic [3:0] b;
	} npc_save_t;
	typedef struct packed {
		logic [14:0] rsv;
		logic global_irq_enable;
		logic [2:0] sp;
		logic skip;
		logic carry;
		logic [2:0] d;
		logic [3:0] b;
		logic [3:0] a;
	} npc_core_t;
	typedef struct packed {
		logic [9:0] rsv;
		logic [3:0] mem;
		logic [9:0] dp;
		logic [7:0] e;
	} npc_data_t;
	typedef struct packed {
		logic [15:0] rsv;
		logic [7:0] en;
		logic [7:0] req;
	} npc_irq_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_LOAD = 3'b100
	} npc_state_t;
endpackage : npc_pkg

// File: tb/npc_core_tb_top.sv
// Self-checking bench for the program-control core
`timescale 1ns/10ps
module npc_core_tb_top;
	import npc_pkg::*;
	// ============================================================
	// Signals and expected state
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] address_i = 5'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [31:0] readdata_o;
	logic waitrequest_o;
	logic [12:0] rom_addr_o;
	logic [9:0] rom_data_i;
	logic [7:0] irq_event_i;
	logic [7:0] fire = 8'h00;
	logic backup_return_i = 1'b0;
	logic [7:0] port_d_i = 8'h00;
	logic [7:0] port_d_o;
	int mismatches = 0;
	int checked = 0;
	int seed = 29;
	logic [31:0] exp_q[$];
	logic [31:0] sv;
	logic [31:0] snap;
	logic [3:0] ea, eb, m;
	logic [2:0] ed, esp;
	logic ec, esk, eie;
	logic [7:0] ee;
	// ============================================================
	// Design and far-side model
	npc_core i_npc_core (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .byteenable_i(4'hf), .writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
		.irq_event_i(irq_event_i), .backup_return_i(backup_return_i), .port_d_i(port_d_i),
		.port_d_o(port_d_o));
	npc_rom_model i_npc_rom_model (.clk_i(clk_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
		.fire_i(fire), .irq_event_o(irq_event_i));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// ============================================================
	// Helpers
	function automatic logic [31:0] core_w();
		return {15'h0, eie, esp, esk, ec, ed, eb, ea};
	endfunction : core_w
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		address_i <= a;
		write_i <= w;
		read_i <= ~w;
		writedata_i <= d;
		@(posedge clk_i);
		while (waitrequest_o !== 1'b0) begin
			n++;
			if (n > 50) begin
				mismatches++;
				final_report();
			end
			@(posedge clk_i);
		end
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask : rd
	task automatic cmd(input logic [4:0] op, input logic [12:0] arg);
		bus(OFS_CMD, 1'b1, {14'h0, arg, op});
	endtask : cmd
	task automatic pulse(input logic [7:0] s);
		@(posedge clk_i);
		fire <= s;
		@(posedge clk_i);
		fire <= 8'h00;
	endtask : pulse
	// ============================================================
	// Read monitor: oldest note against each granted read
	always @(posedge clk_i) begin
		if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
			sv = exp_q.pop_front();
			checked++;
			if (readdata_o !== sv) begin
				$display("[FAIL] t=%0t got %h exp %h", $time, readdata_o, sv);
				mismatches++;
			end
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		{ea, eb, ed, ec, esk, eie, ee} = '0;
		esp = SP_RESET;
		rd(OFS_CORE, core_w());
		rd(OFS_PC, 32'h0);
		$display("Test reset done");
		for (int i = 0; i < 8; i++) begin
			ea = 4'($random(seed));
			m = 4'($random(seed));
			ec = i[0];
			cmd(OP_LOAD_A, {9'h0, ea});
			cmd(ec ? OP_CARRY_ONE : OP_CARRY_ZERO, 13'h0);
			rd(OFS_CORE, core_w());
			cmd(OP_ADD_IMM, {9'h0, m});
			cmd(OP_MEM_ADD, {9'h0, m});
			ea = ea + m + m;
			rd(OFS_CORE, core_w());
			cmd(OP_ADD_CARRY, {9'h0, m});
			{ec, ea} = {1'b0, ea} + {1'b0, m} + {4'h0, ec};
			rd(OFS_CORE, core_w());
			cmd(OP_ROT_RIGHT, 13'h0);
			{ea, ec} = {ec, ea};
			rd(OFS_CORE, core_w());
		end
		$display("Test carry done");
		eb = 4'($random(seed));
		cmd(OP_LOAD_B, {9'h0, eb});
		ee = {eb, ea};
		cmd(OP_E_FROM_AB, 13'h0);
		cmd(OP_LOAD_A, 13'h0);
		cmd(OP_LOAD_B, 13'h0);
		cmd(OP_AB_FROM_E, 13'h0);
		rd(OFS_CORE, core_w());
		cmd(OP_LOAD_DP, 13'h02c3);
		cmd(OP_BIT_SET, 13'h0021);
		rd(OFS_DATA, {10'h0, 4'h5, 10'h2c3, ee});
		cmd(OP_PORT_SET, 13'h0);
		@(negedge clk_i);
		checked++;
		if (port_d_o !== 8'h08) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, port_d_o, 8'h08);
			mismatches++;
		end
		cmd(OP_BIT_TEST, 13'h0015);
		esk = 1'b1;
		rd(OFS_CORE, core_w());
		cmd(OP_LOAD_A, 13'h000f);
		esk = 1'b0;
		rd(OFS_CORE, core_w());
		@(posedge clk_i);
		port_d_i <= 8'($random(seed)) & 8'hf7;
		cmd(OP_PORT_TEST, 13'h0);
		cmd(OP_PORT_CLR, 13'h0);
		@(negedge clk_i);
		checked++;
		if (port_d_o !== 8'h08) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, port_d_o, 8'h08);
			mismatches++;
		end
		cmd(OP_PORT_CLR, 13'h0);
		@(negedge clk_i);
		checked++;
		if (port_d_o !== 8'h00) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, port_d_o, 8'h00);
			mismatches++;
		end
		cmd(OP_BIT_CLR, 13'h002f);
		rd(OFS_DATA, {10'h0, 4'hb, 10'h2c3, ee});
		$display("Test exchange and bits done");
		cmd(OP_BRANCH, 13'h0200);
		for (int k = 0; k < 9; k++) begin
			cmd(OP_CALL, 13'h0300 + 13'(16 * k));
			esp = esp + 3'h1;
		end
		rd(OFS_PC, 32'h0380);
		cmd(OP_SP_TO_A, 13'h0);
		ea = {1'b0, esp};
		rd(OFS_CORE, core_w());
		cmd(OP_RETURN, 13'h0);
		rd(OFS_PC, 32'h0371);
		cmd(OP_RETURN, 13'h0);
		esp = esp - 3'h2;
		rd(OFS_PC, 32'h0361);
		cmd(OP_SHORT_CALL, 13'h0045);
		rd(OFS_PC, 32'h0145);
		cmd(OP_RETURN, 13'h0);
		rd(OFS_PC, 32'h0362);
		cmd(OP_BRANCH, 13'h047f);
		cmd(OP_NOP, 13'h0);
		rd(OFS_PC, 32'h0480);
		@(posedge clk_i);
		backup_return_i <= 1'b1;
		@(posedge clk_i);
		backup_return_i <= 1'b0;
		esp = SP_RESET;
		rd(OFS_CORE, core_w());
		$display("Test stack done");
		ed = 3'h5;
		ea = 4'ha;
		cmd(OP_LOAD_D, {10'h0, ed});
		cmd(OP_LOAD_A, {9'h0, ea});
		cmd(OP_TABLE_READ, 13'h0011);
		@(negedge clk_i);
		checked++;
		if (rom_addr_o !== {6'h11, ed, ea}) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, rom_addr_o, {6'h11, ed, ea});
			mismatches++;
		end
		{eb, ea} = 8'({6'h11, ed, ea} ^ 13'h0036);
		rd(OFS_CORE, core_w());
		rd(OFS_PC, 32'h0483);
		cmd(OP_IND_CALL, 13'h0003);
		rd(OFS_PC, {19'h0, 6'h03, ed, ea});
		cmd(OP_RETURN, 13'h0);
		rd(OFS_PC, 32'h0484);
		cmd(OP_IND_BRANCH, 13'h0004);
		rd(OFS_PC, {19'h0, 6'h04, ed, ea});
		$display("Test table read done");
		cmd(OP_BRANCH, 13'h0400);
		bus(OFS_IRQ, 1'b1, 32'h0400);
		pulse(8'h04);
		rd(OFS_IRQ, 32'h0404);
		ea = 4'h9;
		eb = 4'h6;
		ec = 1'b1;
		cmd(OP_LOAD_A, {9'h0, ea});
		cmd(OP_LOAD_B, {9'h0, eb});
		cmd(OP_CARRY_ONE, 13'h0);
		cmd(OP_IRQ_ON, 13'h0);
		rd(OFS_PC, 32'h0404);
		snap = core_w();
		cmd(OP_NOP, 13'h0);
		rd(OFS_PC, 32'h0084);
		rd(OFS_IRQ, 32'h0400);
		esp = esp + 3'h1;
		rd(OFS_CORE, core_w());
		cmd(OP_LOAD_A, 13'h0001);
		cmd(OP_CARRY_ZERO, 13'h0);
		cmd(OP_IRQ_RETURN, 13'h0);
		esp = esp - 3'h1;
		rd(OFS_CORE, snap);
		rd(OFS_PC, 32'h0405);
		pulse(8'h04);
		cmd(OP_IRQ_SKIP, 13'h0002);
		rd(OFS_IRQ, 32'h0404);
		bus(OFS_IRQ, 1'b1, 32'h0);
		cmd(OP_IRQ_SKIP, 13'h0002);
		rd(OFS_IRQ, 32'h0);
		cmd(OP_LOAD_A, 13'h000f);
		rd(OFS_CORE, snap);
		$display("Test interrupt entry done");
		pulse(8'h04);
		cmd(OP_BRANCH, 13'h0500);
		cmd(OP_IRQ_ON, 13'h0);
		cmd(OP_NOP, 13'h0);
		cmd(OP_IRQ_OFF, 13'h0);
		bus(OFS_IRQ, 1'b1, 32'h0400);
		rd(OFS_PC, 32'h0503);
		cmd(OP_IRQ_ON, 13'h0);
		cmd(OP_NOP, 13'h0);
		rd(OFS_PC, 32'h0084);
		cmd(OP_IRQ_RETURN, 13'h0);
		rd(OFS_PC, 32'h0505);
		$display("Test interrupt gating done");
		final_report();
	end
endmodule : npc_core_tb_top

// File: tb/npc_rom_model.sv
// Program memory and interrupt source model facing the core
`timescale 1ns/10ps
module npc_rom_model (
	// Clock
	input wire logic clk_i,
	// Program memory
	input wire logic [12:0] rom_addr_i,
	output logic [9:0] rom_data_o,
	// Interrupt sources
	input wire logic [7:0] fire_i,
	output logic [7:0] irq_event_o
);
	// ============================================================
	// Ten-bit words, pattern varies with every address bit
	assign rom_data_o = rom_addr_i[9:0] ^ {rom_addr_i[12:10], 7'h36};
	// ============================================================
	// One-cycle event per source request
	always_ff @(posedge clk_i) begin
		irq_event_o <= fire_i;
	end
endmodule : npc_rom_model
